/* rtl/xba_crossbar.sv */
// Partially connected crossbar with per-target arbitration and memory port scheduling
`timescale 1ns/10ps
module xba_crossbar
   import xba_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic srst_i,
   input wire logic ce_i,
   input wire xba_req_t mst_req_i [NUM_MST],
   input wire logic periph_tick_i,
   input wire logic page_en_i,
   input wire logic core_page_wr_i,
   input wire logic [15:0] core_page_base_i,
   input wire logic core_da_req_i,
   input wire logic core_db_req_i,
   input wire logic fetch_req_i,
   output xba_tgt_t tgt_o [NUM_TGT],
   output logic [NUM_MST-1:0] ack_o,
   output logic host_err_o,
   output logic [3:0] mem_gnt_o,
   output logic [15:0] page_base_o
);
   logic [15:0] page_base;
   logic [1:0] tgt_sel [NUM_MST];
   logic [NUM_MST-1:0] legal;
   logic [NUM_MST-1:0] arb_req [NUM_TGT];
   logic [NUM_MST-1:0] arb_gnt [NUM_TGT];
   logic [NUM_MST-1:0] next_ack;
   logic host_block;
   logic sys_busy;
   logic [1:0] slots_used;

   function automatic logic [1:0] tgt_of(input logic [31:0] addr);
      if (addr[REGION_HI:REGION_LO] == REGION_MEM) begin
         return T_MEM;
      end else if (addr[REGION_HI:REGION_LO] == REGION_PERIPH) begin
         return T_PERIPH;
      end
      return T_EXT;
   endfunction

   // Host page window, written only from the core side
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         page_base <= PAGE_RESET;
      end else if (ce_i && core_page_wr_i) begin
         page_base <= core_page_base_i;
      end
   end

   always_comb begin
      host_block = 1'b0;
      for (int m = 0; m < NUM_MST; m++) begin
         tgt_sel[m] = tgt_of(mst_req_i[m].addr);
         // A master just acked must drop its request first
         legal[m] = mst_req_i[m].valid && !ack_o[m];
         // Peripheral side only moves on its own clock tick
         if (tgt_sel[m] == T_PERIPH && !periph_tick_i) begin
            legal[m] = 1'b0;
         end
      end
      if (mst_req_i[M_HOST].valid && !ack_o[M_HOST]) begin
         if (tgt_sel[M_HOST] == T_PERIPH) begin
            host_block = 1'b1;
         end
         if (page_en_i && mst_req_i[M_HOST].addr[PAGE_HI:PAGE_LO] != page_base) begin
            host_block = 1'b1;
         end
      end
      if (host_block) begin
         legal[M_HOST] = 1'b0;
      end
   end

   // One arbiter per target, none sees another target's requests
   for (genvar t = 0; t < NUM_TGT; t++) begin : g_tgt
      always_comb begin
         for (int m = 0; m < NUM_MST; m++) begin
            arb_req[t][m] = legal[m] && (tgt_sel[m] == 2'(t));
         end
      end
      xba_fixed_arb u_arb (
         .req_i(arb_req[t]),
         .gnt_o(arb_gnt[t])
      );
   end

   // Engine channels on distinct targets both win in one cycle
   always_comb begin
      next_ack = '0;
      for (int t = 0; t < NUM_TGT; t++) begin
         next_ack = next_ack | arb_gnt[t];
      end
   end

   // Registered target requests
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         for (int t = 0; t < NUM_TGT; t++) begin
            tgt_o[t] <= '0;
         end
      end else if (ce_i) begin
         for (int t = 0; t < NUM_TGT; t++) begin
            tgt_o[t] <= '0;
            for (int m = 0; m < NUM_MST; m++) begin
               if (arb_gnt[t][m]) begin
                  tgt_o[t].valid <= 1'b1;
                  tgt_o[t].we <= mst_req_i[m].we;
                  tgt_o[t].addr <= mst_req_i[m].addr;
                  tgt_o[t].wdata <= mst_req_i[m].wdata;
                  tgt_o[t].src <= 2'(m);
               end
            end
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         ack_o <= '0;
         host_err_o <= 1'b0;
      end else if (ce_i) begin
         ack_o <= next_ack;
         host_err_o <= host_block;
      end
   end

   // Memory controller: the memory-target grant is the system port
   assign sys_busy = arb_gnt[T_MEM] != '0;
   assign slots_used = 2'(core_da_req_i) + 2'(core_db_req_i) + 2'(sys_busy);

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         mem_gnt_o <= '0;
      end else if (ce_i) begin
         // Core data never waits, so it stays single cycle
         mem_gnt_o[MP_CORE_A] <= core_da_req_i;
         mem_gnt_o[MP_CORE_B] <= core_db_req_i;
         mem_gnt_o[MP_SYS] <= sys_busy;
         // Fetch yields only when three others hold the slots
         mem_gnt_o[MP_FETCH] <= fetch_req_i && (slots_used < MEM_SLOTS);
      end
   end

   // Loaded from core_page_base_i alongside the internal copy so the output never lags the check
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         page_base_o <= PAGE_RESET;
      end else if (ce_i && core_page_wr_i) begin
         page_base_o <= core_page_base_i;
      end
   end
endmodule

/* rtl/xba_pkg.sv */
// Package of constants and carrier types for the master-to-target crossbar
// How it works
// - Different targets serve different masters concurrently
// - Collisions granted: engine, host port, core
// - Host port master never reaches peripherals
// - Memory serves three of four ports
// - Core data ports granted every cycle
// - System memory port carries one master
// - Host confined to core-set 64K page
// - Two engine channels run on different targets
// - Peripheral targets advance on peripheral clock tick
package xba_pkg;
   localparam int NUM_MST = 4;
   localparam int NUM_TGT = 3;
   // Master indices, lowest index wins
   localparam int M_DME0 = 0;
   localparam int M_DME1 = 1;
   localparam int M_HOST = 2;
   localparam int M_CORE = 3;
   // Target indices
   localparam logic [1:0] T_MEM = 2'h0;
   localparam logic [1:0] T_PERIPH = 2'h1;
   localparam logic [1:0] T_EXT = 2'h2;
   // Address decode on the top nibble
   localparam int REGION_HI = 31;
   localparam int REGION_LO = 28;
   localparam logic [3:0] REGION_MEM = 4'h1;
   localparam logic [3:0] REGION_PERIPH = 4'h4;
   // Host page window: upper half of address
   localparam int PAGE_HI = 31;
   localparam int PAGE_LO = 16;
   localparam logic [15:0] PAGE_RESET = 16'h0000;
   // Memory controller slots and port bits
   localparam logic [1:0] MEM_SLOTS = 2'h3;
   localparam int MP_CORE_A = 0;
   localparam int MP_CORE_B = 1;
   localparam int MP_FETCH = 2;
   localparam int MP_SYS = 3;

   typedef struct packed {
      logic valid;
      logic we;
      logic [31:0] addr;
      logic [31:0] wdata;
   } xba_req_t;

   typedef struct packed {
      logic valid;
      logic we;
      logic [31:0] addr;
      logic [31:0] wdata;
      logic [1:0] src;
   } xba_tgt_t;
endpackage

/* rtl/xba_fixed_arb.sv */
// Fixed-priority one-hot arbiter for a single target
`timescale 1ns/10ps
module xba_fixed_arb
   import xba_pkg::*;
(
   input wire logic [NUM_MST-1:0] req_i,
   output logic [NUM_MST-1:0] gnt_o
);
   always_comb begin
      gnt_o = '0;
      // Lowest index wins: engine channels, host port, then core
      for (int i = NUM_MST - 1; i >= 0; i--) begin
         if (req_i[i]) begin
            gnt_o = '0;
            gnt_o[i] = 1'b1;
         end
      end
   end
endmodule

/* testbench/xba_chk_assertions.sv */
// Port checker for the crossbar
`timescale 1ns/10ps
module xba_chk
   import xba_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic srst_i,
   input wire logic ce_i,
   input wire xba_req_t mst_req_i [NUM_MST],
   input wire logic page_en_i,
   input wire logic core_page_wr_i,
   input wire logic [15:0] core_page_base_i,
   input wire logic core_da_req_i,
   input wire xba_tgt_t tgt_o [NUM_TGT],
   input wire logic [NUM_MST-1:0] ack_o,
   input wire logic host_err_o,
   input wire logic [3:0] mem_gnt_o,
   input wire logic [15:0] page_base_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (srst_i);
   wire logic m0 = ce_i && mst_req_i[0].valid && !ack_o[0];
   wire logic m1 = ce_i && mst_req_i[1].valid && !ack_o[1];
   wire logic h = ce_i && page_en_i && !core_page_wr_i && mst_req_i[2].valid && !ack_o[2];
   property p_par; m0 && m1 && mst_req_i[0].addr[31:28] == 4'h1
      && mst_req_i[1].addr[31:28] == 4'h2 |=> ack_o[1:0] == 2'h3; endproperty
   property p_pri; m0 && mst_req_i[0].addr[31:28] == 4'h1 |=> ack_o[0]
      && tgt_o[0].src == 2'h0; endproperty
   property p_hper; tgt_o[1].valid |-> tgt_o[1].src != 2'h2; endproperty
   property p_core; ce_i && core_da_req_i |=> mem_gnt_o[0]; endproperty
   property p_cnt; $countones(mem_gnt_o) <= 3; endproperty
   property p_sys; mem_gnt_o[3] == tgt_o[0].valid; endproperty
   property p_page; ce_i && core_page_wr_i |=> page_base_o == $past(core_page_base_i); endproperty
   property p_off; h && mst_req_i[2].addr[31:16] != page_base_o |=> host_err_o && !ack_o[2];
   endproperty
   a_par: assert property (p_par) else $error("parallel grant missing");
   a_pri: assert property (p_pri) else $error("engine not first");
   a_hper: assert property (p_hper) else $error("host reached periph");
   a_core: assert property (p_core) else $error("core port not granted");
   a_cnt: assert property (p_cnt) else $error("over three memory grants");
   a_sys: assert property (p_sys) else $error("system port mismatch");
   a_page: assert property (p_page) else $error("page base not loaded");
   a_off: assert property (p_off) else $error("off page host taken");
   c_err: cover property (host_err_o);
   c_par: cover property (ack_o[1:0] == 2'h3);
   c_mem: cover property ($countones(mem_gnt_o) == 3);
endmodule
bind xba_crossbar xba_chk u_chk (.clk_sys_i, .srst_i, .ce_i, .mst_req_i, .page_en_i,
   .core_page_wr_i, .core_page_base_i, .core_da_req_i, .tgt_o, .ack_o, .host_err_o,
   .mem_gnt_o, .page_base_o);

/* testbench/xba_mst_model.sv */
// Bus master model holding a request until acknowledged
`timescale 1ns/10ps
module xba_mst_model
   import xba_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic go_i,
   input wire xba_req_t req_i,
   input wire logic ack_i,
   output xba_req_t req_o
);
   initial req_o = '0;
   // Released address inverted so stale values never match
   always @(posedge clk_sys_i) begin
      if (ack_i) begin
         req_o.valid <= 1'b0;
         req_o.addr <= ~req_o.addr;
      end else if (go_i) begin
         req_o <= req_i;
      end
   end
endmodule

/* testbench/xba_crossbar_tb.sv */
// Testbench for the crossbar
`timescale 1ns/10ps
module xba_crossbar_tb
   import xba_pkg::*;
;
   logic clk_sys_i = 0, srst_i = 1, tick = 0, pen = 0, pwr = 0, da = 0, db = 0, fe = 0, herr;
   logic [15:0] pbase = '0, pb;
   logic [3:0] go = '0, ack, mg;
   xba_req_t rq [NUM_MST], mst [NUM_MST];
   xba_tgt_t tgt [NUM_TGT];
   int error_cnt = 0, n_compared = 0;
   initial forever #2.5 clk_sys_i = ~clk_sys_i;
   always @(negedge clk_sys_i) tick <= ~tick;
   for (genvar i = 0; i < NUM_MST; i++) begin : g_m
      xba_mst_model u_m (.clk_sys_i, .go_i(go[i]), .req_i(rq[i]), .ack_i(ack[i]), .req_o(mst[i]));
   end
   xba_crossbar dut (.clk_sys_i, .srst_i, .ce_i(1'b1), .mst_req_i(mst), .periph_tick_i(tick),
      .page_en_i(pen), .core_page_wr_i(pwr), .core_page_base_i(pbase), .core_da_req_i(da),
      .core_db_req_i(db), .fetch_req_i(fe), .tgt_o(tgt), .ack_o(ack), .host_err_o(herr),
      .mem_gnt_o(mg), .page_base_o(pb));
   task automatic chk(input logic [31:0] seen, exp, input string what);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH %s exp %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wrap_up;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic req(input int m, input logic [31:0] a, input logic v = 1'b1);
      rq[m] = '{v, 1'b0, a, 32'h5a};
      go[m] = 1'b1;
   endtask
   task automatic fire;
      @(negedge clk_sys_i);
      go = '0;
   endtask
   // Bounded wait; a hang ends the run
   task automatic wack(input int m);
      int k;
      for (k = 0; k < 30 && ack[m] !== 1'b1; k++) @(negedge clk_sys_i);
      if (k == 30) begin
         error_cnt++;
         wrap_up();
      end
   endtask
   task automatic bad(input logic [31:0] a);
      req(2, a);
      fire();
      @(negedge clk_sys_i);
      chk({herr, ack[2]}, 2'h2, "host refused");
      req(2, a, 1'b0);
      fire();
   endtask
   task automatic t_par;
      req(0, 32'h1000_0000);
      req(1, 32'h2000_0000);
      fire();
      wack(0);
      chk(ack, 4'h3, "parallel ack");
      chk({tgt[2].valid, tgt[2].src}, 3'h5, "ext target src");
      // Let the acked models release before new requests
      @(negedge clk_sys_i);
      $display("parallel done");
   endtask
   task automatic t_pri;
      {da, db, fe} = 3'h7;
      for (int m = 0; m < 4; m++) req(m, 32'h1000_0040);
      fire();
      for (int m = 0; m < 4; m++) begin
         wack(m);
         chk(ack, 4'h1 << m, "priority ack");
         chk(tgt[0].src, m, "memory src");
         chk(mg, 4'hb, "memory grants");
         @(negedge clk_sys_i);
      end
      chk(mg, 4'h7, "fetch granted");
      {da, db, fe} = 3'h0;
      $display("priority done");
   endtask
   task automatic t_host;
      bad(32'h4000_0000);
      {pen, pwr, pbase} = {2'h3, 16'h1000};
      @(negedge clk_sys_i);
      pwr = 1'b0;
      chk(pb, 16'h1000, "page base");
      bad(32'h1001_0000);
      req(2, 32'h1000_0010);
      fire();
      wack(2);
      req(0, 32'h4000_0004);
      fire();
      wack(0);
      chk(tgt[1].src, 2'h0, "periph src");
      $display("host done");
   endtask
   initial begin
      repeat (5) @(negedge clk_sys_i);
      srst_i = 1'b0;
      t_par();
      t_pri();
      t_host();
      wrap_up();
   end
endmodule
